// ---- core/lvex_core.sv ----
// Low-vector exception detection, resume flag and NMI gating
module lvex_core #(
   parameter int ADDR_W = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic nmi_pin,
   input wire lvex_pkg::lvex_dec_s dec,
   input wire lvex_pkg::lvex_mode_s mode,
   output lvex_pkg::lvex_exc_s exc,
   output logic resume_flag,
   output logic nmi_blocked,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic [lvex_pkg::CTRL_W-1:0] ctrl_r;
   logic [lvex_pkg::DS_W-1:0] dstat_r, ds_set;
   lvex_pkg::lvex_exc_s exc_r, exc_nxt;
   logic rf_r, nmi_s1_r, nmi_s2_r, nmi_s3_r, nmi_pend_r, nmi_blk_r;
   logic [4:0] bp_en;
   logic ibp_c, gd_c, dbf_c, ud_c, nm_c, de_c, br_c, bp_c, of_c, dbt_c;
   logic fault_any, nmi_take, done_ok, wr_do;
   logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      hit = (a == ADDR_W'(off));
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, lvex_pkg::OFF_CTRL) | hit(a, lvex_pkg::OFF_DSTAT)
         | hit(a, lvex_pkg::OFF_STATE);
   endfunction

   assign bp_en = ctrl_r[lvex_pkg::CTRL_BPEN +: 5];
   // Cause detection
   always_comb begin
      ibp_c = dec.bp_hit[0] & bp_en[0] & ~rf_r;
      gd_c = dec.dr_access & ctrl_r[lvex_pkg::CTRL_GD];
      dbf_c = ibp_c | gd_c | dec.dr_invalid;
      ud_c = dec.rsvd_op | dec.undef_insn | dec.lock_bad | dec.bad_oper;
      ud_c = ud_c | (dec.legacy64 & mode.long64) | (dec.sys_fast & mode.long_mode);
      ud_c = ud_c | (dec.sys_desc & (~mode.prot_en | mode.v86))
         | (dec.smm_exit & ~mode.in_smm);
      ud_c = ud_c | (dec.legacy_vec & ~ctrl_r[lvex_pkg::CTRL_OSFX])
         | (dec.vec_media & ctrl_r[lvex_pkg::CTRL_EM])
         | (dec.vec_numexc & ~ctrl_r[lvex_pkg::CTRL_OSXE]);
      ud_c = ud_c | (dec.dr_access & ctrl_r[lvex_pkg::CTRL_DE]
         & (dec.dr_idx == 3'h4 | dec.dr_idx == 3'h5));
      nm_c = dec.fp_wait & ctrl_r[lvex_pkg::CTRL_MP] & ctrl_r[lvex_pkg::CTRL_TS];
      nm_c = nm_c | (dec.fp_insn & (ctrl_r[lvex_pkg::CTRL_EM] | ctrl_r[lvex_pkg::CTRL_TS]))
         | (dec.media_insn & ctrl_r[lvex_pkg::CTRL_TS]);
      de_c = dec.is_div & (dec.div_zero | dec.div_ovf);
      br_c = dec.bound & dec.bound_out;
      bp_c = dec.one_byte_breakpoint_insn;
      of_c = dec.into & mode.overflow_flag;
      dbt_c = dec.one_byte_debug_trap_insn | (|(dec.bp_hit[4:1] & bp_en[4:1])) | mode.trap_flag;
      fault_any = dbf_c | ud_c | nm_c | de_c | br_c;
      done_ok = dec.valid & ~fault_any;
      nmi_take = dec.valid & nmi_pend_r & ~nmi_blk_r & ~fault_any
         & ~bp_c & ~of_c & ~dbt_c;
   end

   // Single event per boundary, fixed priority
   always_comb begin
      exc_nxt = '0;
      exc_nxt.valid = dec.valid;
      exc_nxt.pushed_rf = 1'b1;
      if (dbf_c) begin
         exc_nxt.vector = lvex_pkg::VEC_DB;
         exc_nxt.pushed_rf = 1'b0;
      end else if (ud_c) begin
         exc_nxt.vector = lvex_pkg::VEC_UD;
      end else if (nm_c) begin
         exc_nxt.vector = lvex_pkg::VEC_NM;
      end else if (de_c) begin
         exc_nxt.vector = lvex_pkg::VEC_DE;
      end else if (br_c) begin
         exc_nxt.vector = lvex_pkg::VEC_BR;
      end else if (bp_c) begin
         exc_nxt.vector = lvex_pkg::VEC_BP;
         exc_nxt.is_trap = 1'b1;
      end else if (of_c) begin
         exc_nxt.vector = lvex_pkg::VEC_OF;
         exc_nxt.is_trap = 1'b1;
      end else if (dbt_c) begin
         exc_nxt.vector = lvex_pkg::VEC_DB;
         exc_nxt.is_trap = 1'b1;
         exc_nxt.pushed_rf = 1'b0;
      end else if (nmi_take) begin
         exc_nxt.vector = lvex_pkg::VEC_NMI;
         exc_nxt.is_trap = 1'b1;
         exc_nxt.pushed_rf = dec.str_intr | rf_r;
      end else begin
         exc_nxt.valid = 1'b0;
      end
      exc_nxt.err_valid = 1'b0;
      if (!exc_nxt.valid) begin
         exc_nxt.vector = exc_r.vector;
      end
   end

   // Status causes recorded with a debug event
   always_comb begin
      ds_set = '0;
      if (dec.valid & exc_nxt.valid & exc_nxt.vector == lvex_pkg::VEC_DB) begin
         ds_set[lvex_pkg::DS_BP +: 5] = dec.bp_hit & bp_en & {4'hf, ~rf_r};
         ds_set[lvex_pkg::DS_BS] = mode.trap_flag;
         ds_set[lvex_pkg::DS_BD] = gd_c;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         exc_r <= '0;
      end else if (ce) begin
         exc_r <= exc_nxt;
      end
   end

   // Resume flag tracking
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rf_r <= 1'b0;
      end else if (ce && done_ok) begin
         if (dec.is_interrupt_return_insn) begin
            rf_r <= dec.popped_rf;
         end else if (!dec.rf_defer) begin
            rf_r <= 1'b0;
         end
      end
   end

   // NMI pin synchroniser and edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nmi_s1_r <= 1'b0;
         nmi_s2_r <= 1'b0;
         nmi_s3_r <= 1'b0;
      end else if (ce) begin
         nmi_s1_r <= nmi_pin;
         nmi_s2_r <= nmi_s1_r;
         nmi_s3_r <= nmi_s2_r;
      end
   end

   // NMI pending and blocking
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nmi_pend_r <= 1'b0;
         nmi_blk_r <= 1'b0;
      end else if (ce) begin
         if (nmi_take) begin
            nmi_pend_r <= 1'b0;
         end else if (nmi_s2_r && !nmi_s3_r && !nmi_blk_r) begin
            nmi_pend_r <= 1'b1;
         end
         if (nmi_take) begin
            nmi_blk_r <= 1'b1;
         end else if (done_ok && dec.is_interrupt_return_insn) begin
            nmi_blk_r <= 1'b0;
         end
      end
   end

   // Write channel
   assign wr_do = aw_got_r & w_got_r & ~bvalid_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= lvex_pkg::RESP_OK;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && awready_r) begin
            aw_got_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            w_got_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_do) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= mapped(awaddr_r) ? lvex_pkg::RESP_OK : lvex_pkg::RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Control register, byte lanes 0 and 1
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r <= lvex_pkg::CTRL_RST;
      end else if (ce && wr_do && hit(awaddr_r, lvex_pkg::OFF_CTRL)) begin
         if (wstrb_r[0]) begin
            ctrl_r[7:0] <= wdata_r[7:0];
         end
         if (wstrb_r[1]) begin
            ctrl_r[11:8] <= wdata_r[11:8];
         end
      end
   end

   // Debug status: write one to clear, new cause wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dstat_r <= lvex_pkg::DS_RST;
      end else if (ce) begin
         if (wr_do && wstrb_r[0] && hit(awaddr_r, lvex_pkg::OFF_DSTAT)) begin
            dstat_r <= (dstat_r & ~wdata_r[lvex_pkg::DS_W-1:0]) | ds_set;
         end else begin
            dstat_r <= dstat_r | ds_set;
         end
      end
   end

   // Read channel
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= lvex_pkg::RESP_OK;
      end else if (ce) begin
         if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= mapped(s_axi_araddr) ? lvex_pkg::RESP_OK : lvex_pkg::RESP_SLVERR;
            rdata_r <= '0;
            if (hit(s_axi_araddr, lvex_pkg::OFF_CTRL)) begin
               rdata_r[lvex_pkg::CTRL_W-1:0] <= ctrl_r;
            end else if (hit(s_axi_araddr, lvex_pkg::OFF_DSTAT)) begin
               rdata_r[lvex_pkg::DS_W-1:0] <= dstat_r;
            end else if (hit(s_axi_araddr, lvex_pkg::OFF_STATE)) begin
               rdata_r[lvex_pkg::ST_VEC +: 8] <= exc_r.vector;
               rdata_r[lvex_pkg::ST_RF] <= rf_r;
               rdata_r[lvex_pkg::ST_PEND] <= nmi_pend_r;
               rdata_r[lvex_pkg::ST_BLK] <= nmi_blk_r;
            end
         end
         if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   assign exc = exc_r;
   assign resume_flag = rf_r;
   assign nmi_blocked = nmi_blk_r;
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   div_fault_a:
   assert property (ce && dec.valid && dec.is_div && dec.div_zero && !dbf_c && !ud_c && !nm_c
      |=> exc.valid && exc.vector == lvex_pkg::VEC_DE && !exc.is_trap && !exc.err_valid)
      else $error("divide error not raised as fault");
   gen_detect_a:
   assert property (ce && dec.valid && dec.dr_access && ctrl_r[lvex_pkg::CTRL_GD]
      |=> exc.valid && exc.vector == lvex_pkg::VEC_DB && !exc.is_trap
      && dstat_r[lvex_pkg::DS_BD])
      else $error("general detect not faulted");
   dbg_rf_push_a:
   assert property (exc.valid && exc.vector == lvex_pkg::VEC_DB |-> !exc.pushed_rf)
      else $error("debug event pushed resume flag set");
   exc_rf_push_a:
   assert property (exc.valid && exc.vector != lvex_pkg::VEC_DB
      && exc.vector != lvex_pkg::VEC_NMI |-> exc.pushed_rf)
      else $error("exception pushed resume flag clear");
   rf_clear_a:
   assert property (ce && done_ok && !dec.rf_defer && !dec.is_interrupt_return_insn |=> !resume_flag)
      else $error("resume flag not cleared");
   rf_defer_a:
   assert property (ce && done_ok && dec.rf_defer && !dec.is_interrupt_return_insn
      |=> resume_flag == $past(resume_flag))
      else $error("resume flag deferral wrong");
   ibp_suppress_a:
   assert property (ce && dec.valid && resume_flag && dec.bp_hit == 5'h01 && !dec.dr_invalid
      && !gd_c && !ud_c && !nm_c && !de_c && !br_c && !bp_c && !of_c && !dbt_c
      |=> !(exc.valid && exc.vector == lvex_pkg::VEC_DB))
      else $error("instruction breakpoint not suppressed");
   nmi_block_a:
   assert property (ce && nmi_blocked && !(done_ok && dec.is_interrupt_return_insn)
      |=> nmi_blocked && !(exc.valid && exc.vector == lvex_pkg::VEC_NMI))
      else $error("nested NMI accepted");
   nmi_take_a:
   assert property (ce && nmi_take |=> exc.valid && exc.vector == lvex_pkg::VEC_NMI
      && !exc.err_valid && nmi_blocked)
      else $error("NMI not delivered at boundary");
   of_gate_a:
   assert property (ce && dec.valid && dec.into && !mode.overflow_flag
      |=> !(exc.valid && exc.vector == lvex_pkg::VEC_OF))
      else $error("overflow trap without overflow flag");
   wait_gate_a:
   assert property (ce && dec.valid && dec.fp_wait && !dec.fp_insn && !dec.media_insn
      && !(ctrl_r[lvex_pkg::CTRL_MP] && ctrl_r[lvex_pkg::CTRL_TS])
      |=> !(exc.valid && exc.vector == lvex_pkg::VEC_NM))
      else $error("wait raised device-not-available");
   bp_trap_a:
   assert property (ce && dec.valid && dec.one_byte_breakpoint_insn && !fault_any
      |=> exc.valid && exc.vector == lvex_pkg::VEC_BP && exc.is_trap)
      else $error("breakpoint trap missing");
endmodule

// ---- core/lvex_pkg.sv ----
// Constants and carriers for the low-vector exception logic
package lvex_pkg;
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_DSTAT = 12'h004;
   localparam logic [11:0] OFF_STATE = 12'h008;
   localparam int CTRL_MP = 0;
   localparam int CTRL_EM = 1;
   localparam int CTRL_TS = 2;
   localparam int CTRL_OSFX = 3;
   localparam int CTRL_OSXE = 4;
   localparam int CTRL_DE = 5;
   localparam int CTRL_GD = 6;
   localparam int CTRL_BPEN = 7;
   localparam int CTRL_W = 12;
   localparam logic [11:0] CTRL_RST = 12'h000;
   localparam int DS_BP = 0;
   localparam int DS_BS = 5;
   localparam int DS_BD = 6;
   localparam int DS_W = 7;
   localparam logic [6:0] DS_RST = 7'h00;
   localparam int ST_VEC = 0;
   localparam int ST_RF = 8;
   localparam int ST_PEND = 9;
   localparam int ST_BLK = 10;
   localparam logic [7:0] VEC_DE = 8'h00;
   localparam logic [7:0] VEC_DB = 8'h01;
   localparam logic [7:0] VEC_NMI = 8'h02;
   localparam logic [7:0] VEC_BP = 8'h03;
   localparam logic [7:0] VEC_OF = 8'h04;
   localparam logic [7:0] VEC_BR = 8'h05;
   localparam logic [7:0] VEC_UD = 8'h06;
   localparam logic [7:0] VEC_NM = 8'h07;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Breakpoint hit order: insn, data read, data write, io, task switch
   typedef struct packed {
      logic valid;
      logic is_div, div_zero, div_ovf;
      logic one_byte_debug_trap_insn, one_byte_breakpoint_insn, into, bound, bound_out;
      logic rsvd_op, undef_insn, lock_bad, bad_oper;
      logic legacy64, sys_fast, sys_desc, smm_exit;
      logic legacy_vec, vec_media, vec_numexc;
      logic dr_access, dr_invalid;
      logic [2:0] dr_idx;
      logic fp_insn, fp_wait, media_insn;
      logic rf_defer, is_interrupt_return_insn, popped_rf, str_intr;
      logic [4:0] bp_hit;
   } lvex_dec_s;
   typedef struct packed {
      logic long64, long_mode, prot_en, v86, in_smm;
      logic overflow_flag, trap_flag;
   } lvex_mode_s;
   typedef struct packed {
      logic valid;
      logic [7:0] vector;
      logic is_trap;
      logic err_valid;
      logic pushed_rf;
   } lvex_exc_s;
endpackage

// ---- tb/lvex_pipe_model.sv ----
// Pipeline and system-logic model feeding boundary info and the NMI pin
module lvex_pipe_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire lvex_pkg::lvex_dec_s nd,
   input wire lvex_pkg::lvex_mode_s nm,
   input wire logic nmi_go,
   output lvex_pkg::lvex_dec_s dec,
   output lvex_pkg::lvex_mode_s mode,
   output logic nmi_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] nmi_cnt_r;
   // One boundary per cycle with go high, idle in any cycle with go low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dec <= '0;
      end else begin
         dec <= go ? nd : '0;
      end
   end
   always_ff @(posedge clk) begin
      mode <= nm;
   end
   // System logic holds its NMI request three cycles
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nmi_cnt_r <= 2'h0;
      end else if (nmi_go) begin
         nmi_cnt_r <= 2'h3;
      end else if (nmi_cnt_r != 2'h0) begin
         nmi_cnt_r <= nmi_cnt_r - 2'h1;
      end
   end
   assign nmi_pin = (nmi_cnt_r != 2'h0);
endmodule

// ---- tb/lvex_core_tb.sv ----
// Testbench for the low-vector exception logic
module lvex_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, ce, go, nmi_go, nmi_pin, rf, nblk;
   logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   lvex_pkg::lvex_dec_s nd, dec, d, bd;
   lvex_pkg::lvex_mode_s nm, mode, md, bm;
   lvex_pkg::lvex_exc_s exc;
   int bad_count, cmp_count;
   lvex_pipe_model lvex_pipe_model_inst (.clk(clk), .rst_n(rst_n), .go(go), .nd(nd), .nm(nm),
      .nmi_go(nmi_go), .dec(dec), .mode(mode), .nmi_pin(nmi_pin));
   lvex_core lvex_core_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .nmi_pin(nmi_pin),
      .dec(dec), .mode(mode), .exc(exc), .resume_flag(rf), .nmi_blocked(nblk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task ck(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task axw(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      ck("bvalid", 32'h1, 32'(bvalid));
      ck("bresp", 32'(er), 32'(bresp));
   endtask
   task axr(input logic [11:0] a, input logic [31:0] ev, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      ck("rvalid", 32'h1, 32'(rvalid));
      ck("rdata", ev, rdata);
      ck("rresp", 32'(er), 32'(rresp));
   endtask
   // One instruction boundary, then the event it must give
   task run(input logic ev, input logic [7:0] v, input logic tr);
      @(posedge clk);
      go <= 1'b1;
      nd <= d;
      nm <= md;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
      ck("exc_valid", 32'(ev), 32'(exc.valid));
      if (ev) begin
         ck("vector", 32'(v), 32'(exc.vector));
         ck("is_trap", 32'(tr), 32'(exc.is_trap));
         ck("err_valid", 32'h0, 32'(exc.err_valid));
         ck("pushed_rf", 32'(v != lvex_pkg::VEC_DB), 32'(exc.pushed_rf));
      end
      d = bd;
      md = bm;
   endtask
   task nmi();
      @(posedge clk);
      nmi_go <= 1'b1;
      @(posedge clk);
      nmi_go <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      #200000;
      bad_count++;
      give_verdict();
   end
   initial begin
      rst_n = 1'b0;
      go = 1'b0;
      nmi_go = 1'b0;
      ce = 1'b1;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      bad_count = 0;
      cmp_count = 0;
      bd = '0;
      bd.valid = 1'b1;
      bm = '0;
      bm.prot_en = 1'b1;
      d = bd;
      md = bm;
      nd = '0;
      nm = bm;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      axr(lvex_pkg::OFF_CTRL, 32'h0, lvex_pkg::RESP_OK);
      axr(lvex_pkg::OFF_STATE, 32'h0, lvex_pkg::RESP_OK);
      axw(lvex_pkg::OFF_CTRL, 32'hffffffff, lvex_pkg::RESP_OK);
      axr(lvex_pkg::OFF_CTRL, 32'h00000fff, lvex_pkg::RESP_OK);
      axw(lvex_pkg::OFF_STATE, 32'hffffffff, lvex_pkg::RESP_OK);
      axr(lvex_pkg::OFF_STATE, 32'h0, lvex_pkg::RESP_OK);
      axw(12'h00c, 32'h1, lvex_pkg::RESP_SLVERR);
      axr(12'h00c, 32'h0, lvex_pkg::RESP_SLVERR);
      axw(lvex_pkg::OFF_CTRL, 32'h0, lvex_pkg::RESP_OK);
      d.is_div = 1'b1;
      d.div_zero = 1'b1;
      run(1'b1, lvex_pkg::VEC_DE, 1'b0);
      d.is_div = 1'b1;
      d.div_ovf = 1'b1;
      run(1'b1, lvex_pkg::VEC_DE, 1'b0);
      d.is_div = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      d.one_byte_breakpoint_insn = 1'b1;
      run(1'b1, lvex_pkg::VEC_BP, 1'b1);
      d.into = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      d.into = 1'b1;
      md.overflow_flag = 1'b1;
      run(1'b1, lvex_pkg::VEC_OF, 1'b1);
      d.bound = 1'b1;
      d.bound_out = 1'b1;
      run(1'b1, lvex_pkg::VEC_BR, 1'b0);
      for (int i = 0; i < 4; i++) begin
         {d.rsvd_op, d.undef_insn, d.lock_bad, d.bad_oper} = 4'h1 << i;
         run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      end
      d.legacy64 = 1'b1;
      md.long64 = 1'b1;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      d.legacy64 = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      d.sys_fast = 1'b1;
      md.long_mode = 1'b1;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      d.sys_desc = 1'b1;
      md.prot_en = 1'b0;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      d.sys_desc = 1'b1;
      md.v86 = 1'b1;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      d.smm_exit = 1'b1;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      d.smm_exit = 1'b1;
      md.in_smm = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      d.legacy_vec = 1'b1;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      d.vec_numexc = 1'b1;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      d.fp_insn = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      axw(lvex_pkg::OFF_CTRL, 32'h18, lvex_pkg::RESP_OK);
      d.legacy_vec = 1'b1;
      d.vec_numexc = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      axw(lvex_pkg::OFF_CTRL, 32'h2, lvex_pkg::RESP_OK);
      d.fp_insn = 1'b1;
      run(1'b1, lvex_pkg::VEC_NM, 1'b0);
      d.vec_media = 1'b1;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      d.fp_wait = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      axw(lvex_pkg::OFF_CTRL, 32'h4, lvex_pkg::RESP_OK);
      d.media_insn = 1'b1;
      run(1'b1, lvex_pkg::VEC_NM, 1'b0);
      d.fp_wait = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      axw(lvex_pkg::OFF_CTRL, 32'h5, lvex_pkg::RESP_OK);
      d.fp_wait = 1'b1;
      run(1'b1, lvex_pkg::VEC_NM, 1'b0);
      axw(lvex_pkg::OFF_CTRL, 32'h180, lvex_pkg::RESP_OK);
      axw(lvex_pkg::OFF_DSTAT, 32'h7f, lvex_pkg::RESP_OK);
      d.bp_hit = 5'h02;
      run(1'b1, lvex_pkg::VEC_DB, 1'b1);
      axr(lvex_pkg::OFF_DSTAT, 32'h02, lvex_pkg::RESP_OK);
      d.bp_hit = 5'h04;
      run(1'b0, 8'h00, 1'b0);
      md.trap_flag = 1'b1;
      run(1'b1, lvex_pkg::VEC_DB, 1'b1);
      axr(lvex_pkg::OFF_DSTAT, 32'h22, lvex_pkg::RESP_OK);
      d.one_byte_debug_trap_insn = 1'b1;
      run(1'b1, lvex_pkg::VEC_DB, 1'b1);
      d.bp_hit = 5'h01;
      run(1'b1, lvex_pkg::VEC_DB, 1'b0);
      d.is_interrupt_return_insn = 1'b1;
      d.popped_rf = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      ck("resume_flag", 32'h1, 32'(rf));
      d.bp_hit = 5'h01;
      run(1'b0, 8'h00, 1'b0);
      ck("resume_flag", 32'h0, 32'(rf));
      d.bp_hit = 5'h01;
      run(1'b1, lvex_pkg::VEC_DB, 1'b0);
      d.is_interrupt_return_insn = 1'b1;
      d.popped_rf = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      d.rf_defer = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      ck("resume_flag", 32'h1, 32'(rf));
      run(1'b0, 8'h00, 1'b0);
      ck("resume_flag", 32'h0, 32'(rf));
      axw(lvex_pkg::OFF_CTRL, 32'h40, lvex_pkg::RESP_OK);
      d.dr_access = 1'b1;
      run(1'b1, lvex_pkg::VEC_DB, 1'b0);
      axw(lvex_pkg::OFF_CTRL, 32'h20, lvex_pkg::RESP_OK);
      d.dr_access = 1'b1;
      d.dr_idx = 3'h5;
      run(1'b1, lvex_pkg::VEC_UD, 1'b0);
      nmi();
      d.str_intr = 1'b1;
      run(1'b1, lvex_pkg::VEC_NMI, 1'b1);
      ck("nmi_blocked", 32'h1, 32'(nblk));
      axr(lvex_pkg::OFF_STATE, 32'h402, lvex_pkg::RESP_OK);
      nmi();
      run(1'b0, 8'h00, 1'b0);
      d.is_interrupt_return_insn = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      ck("nmi_blocked", 32'h0, 32'(nblk));
      run(1'b0, 8'h00, 1'b0);
      nmi();
      d.one_byte_breakpoint_insn = 1'b1;
      run(1'b1, lvex_pkg::VEC_BP, 1'b1);
      d.str_intr = 1'b1;
      run(1'b1, lvex_pkg::VEC_NMI, 1'b1);
      // Clock enable low freezes event, resume flag and NMI block
      @(posedge clk);
      ce <= 1'b0;
      d.is_interrupt_return_insn = 1'b1;
      d.popped_rf = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      ck("resume_flag", 32'h0, 32'(rf));
      ck("nmi_blocked", 32'h1, 32'(nblk));
      @(posedge clk);
      ce <= 1'b1;
      d.is_interrupt_return_insn = 1'b1;
      run(1'b0, 8'h00, 1'b0);
      ck("nmi_blocked", 32'h0, 32'(nblk));
      give_verdict();
   end
endmodule
